/* core/bio_defs.svh */
// Offsets, field positions, reset values and counts of the board I/O block.
`ifndef BIO_DEFS_SVH
`define BIO_DEFS_SVH
`define BIO_AW 8
`define BIO_OFF_DOUT 8'h00
`define BIO_OFF_OUTCMD 8'h04
`define BIO_OFF_RELAY 8'h08
`define BIO_OFF_LED 8'h0C
`define BIO_OFF_DINSEL 8'h10
`define BIO_OFF_DIN 8'h14
`define BIO_OFF_SERMODE 8'h18
`define BIO_OFF_RS485 8'h1C
`define BIO_OFF_CONFIG 8'h20
`define BIO_OFF_PORTD 8'h24
`define BIO_SEL_LSB 8
`define BIO_SEL_MSB 12
`define BIO_VAL_BIT 0
`define BIO_SER_CODE_MSB 7
`define BIO_SER_ERR_BIT 8
`define BIO_NUM_DOUT 10
`define BIO_NUM_DIN 22
`define BIO_NUM_STD_IN 11
`define BIO_NUM_PSEUDO 11
`define BIO_NUM_OUT_LED 4
`define BIO_FAULT_LED 4
`define BIO_RELAY0 0
`define BIO_SER_MAX_CODE 8'h01
`define BIO_THRESH_MV 2400
`define BIO_FULL_SCALE_MV 4096
`define BIO_ADC_BITS 12
`define BIO_DOUT_RST 10'h000
`define BIO_PORTA_OE 8'hFF
`define BIO_PORTB_OE 8'hC0
`define BIO_PORTD_RST 8'hF3
`define BIO_PORTD_OE 8'hF3
`define BIO_LINK_CLK_BIT 3
`define BIO_FULL_LANES 2'h3
`define BIO_RESP_OKAY 2'h0
`define BIO_RESP_SLVERR 2'h2
`endif

/* core/bio_pkg.sv */
// Types shared by the board I/O block.
package bio_pkg;
	typedef logic [31:0] bio_word_type;
	typedef logic [7:0] bio_addr_type;
	typedef enum logic {
		BIO_SER_THREE_WIRE = 1'b0,
		BIO_SER_FIVE_WIRE = 1'b1
	} bio_sermode_type;
endpackage : bio_pkg

/* core/bio_reg_if.sv */
// Register access strobes between the bus slave and the port logic.
`timescale 1ns/1ps
interface bio_reg_if;
	import bio_pkg::*;
	logic wen;
	bio_addr_type waddr;
	bio_word_type wdata;
	logic [3:0] wstrb;
	logic wok;
	logic ren;
	bio_addr_type raddr;
	bio_word_type rdata;
	logic rok;
	modport bus (output wen, waddr, wdata, wstrb, ren, raddr,
		input wok, rdata, rok);
	modport regs (input wen, waddr, wdata, wstrb, ren, raddr,
		output wok, rdata, rok);
endinterface : bio_reg_if

/* core/bio_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ps
`include "bio_defs.svh"
module bio_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire bio_pkg::bio_word_type wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output bio_pkg::bio_word_type rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	bio_reg_if.bus rb
);
	import bio_pkg::*;
	logic aw_full_r;
	logic w_full_r;
	logic [31:0] aw_addr_r;
	bio_word_type w_data_r;
	logic [3:0] w_strb_r;
	wire aw_hi_zero = aw_addr_r[31:`BIO_AW] == '0;
	wire ar_hi_zero = araddr[31:`BIO_AW] == '0;
	assign awready = !aw_full_r && !bvalid;
	assign wready = !w_full_r && !bvalid;
	assign arready = !rvalid;
	// The strobe fires once both halves of the write are held and the address bits above the block are zero.
	assign rb.wen = aw_full_r && w_full_r && !bvalid && aw_hi_zero;
	assign rb.waddr = aw_addr_r[`BIO_AW-1:0];
	assign rb.wdata = w_data_r;
	assign rb.wstrb = w_strb_r;
	assign rb.ren = arvalid && arready && ar_hi_zero;
	assign rb.raddr = araddr[`BIO_AW-1:0];
	wire wr_done = aw_full_r && w_full_r && !bvalid;
	wire wr_ok = rb.wok && aw_hi_zero;
	wire rd_ok = rb.rok && ar_hi_zero;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			bvalid <= 1'b0;
			bresp <= `BIO_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= `BIO_RESP_OKAY;
			rdata <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			if (wr_done) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? `BIO_RESP_OKAY : `BIO_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= rd_ok ? rb.rdata : '0;
				rresp <= rd_ok ? `BIO_RESP_OKAY : `BIO_RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule : bio_axil_slave

/* core/bio_thresh_cmp.sv */
// One pseudo digital input: converter code compared with a threshold.
`timescale 1ns/1ps
module bio_thresh_cmp #(
	parameter int W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] code,
	input wire logic [W-1:0] thresh,
	output logic level
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= 1'b0;
		end else begin
			level <= code >= thresh;
		end
	end
endmodule : bio_thresh_cmp

/* core/bio_port_ctrl.sv */
// Board I/O port control: outputs, relay, lamps, inputs and serial wiring.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bio_defs.svh"
//
// Behaviour
// - After reset every port bit takes its direction and idle level.
// - Link-clock variant makes port D bit 3 an output, driven high.
// - Input read takes channel 0 to 21 and returns one bit.
// - Channels 11 to 14 compare converter inputs 0 to 3 with threshold.
// - Pseudo input threshold defaults to 2.40 V, set at build time.
// - Outputs 0 to 9 take written value; sinking default, sourcing option.
// - Relay, output 0 and its lamp share one port A bit 0 line.
// - Relay value 0 selects normally closed, 1 normally open contact.
// - Lamp codes 0 to 3 hit output lamps, code 4 the fault lamp.
// - Lighting output 0 lamp also energizes relay and output 0.
// - Mode 0: B and C three-wire; mode 1: B five-wire, C handshake.
// - Serial mode write reports 0 for valid code, 1 otherwise.
// - Transmit on RS-485 drives the driver-enable line high.
// - Receive on RS-485 drives the driver-enable line low.
module bio_port_ctrl #(
	parameter bit LINK_CLK_OUT = 1'b0,
	parameter bit SOURCING = 1'b0,
	parameter int ADC_BITS = `BIO_ADC_BITS,
	parameter int THRESH_MV = `BIO_THRESH_MV,
	parameter int FULL_SCALE_MV = `BIO_FULL_SCALE_MV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire bio_pkg::bio_word_type s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output bio_pkg::bio_word_type s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] porta_out,
	output logic [7:0] porta_oe,
	input wire logic [7:0] portb_in,
	output logic [7:0] portb_out,
	output logic [7:0] portb_oe,
	input wire logic [7:0] portc_in,
	output logic [7:0] portc_out,
	input wire logic [7:0] portd_in,
	output logic [7:0] portd_out,
	output logic [7:0] portd_oe,
	input wire logic [7:0] porte_in,
	output logic [1:0] porte_out,
	input wire logic [`BIO_NUM_PSEUDO*ADC_BITS-1:0] conv_values,
	output logic drive_sourcing,
	output logic relay_energize,
	output logic [4:0] lamps,
	output logic driver_enable_line,
	output logic fault_indicator_bit,
	output bio_pkg::bio_sermode_type serial_mode,
	input wire logic uart_a_txd,
	input wire logic uart_b_txd,
	input wire logic uart_b_rts,
	input wire logic uart_c_txd,
	input wire logic uart_d_txd,
	output logic uart_a_rxd,
	output logic uart_b_rxd,
	output logic uart_b_cts,
	output logic uart_c_rxd,
	output logic uart_d_rxd
);
	import bio_pkg::*;

	bio_reg_if rb ();

	bio_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.rb(rb)
	);

	// The threshold is fixed when the design is built, not by software.
	// build-time threshold
	localparam int THRESH_CODE_INT =
		(THRESH_MV * (2 ** ADC_BITS)) / FULL_SCALE_MV;
	wire [ADC_BITS-1:0] thresh_code = ADC_BITS'(THRESH_CODE_INT);
	localparam logic [7:0] PORTD_RST = `BIO_PORTD_RST |
		(8'(LINK_CLK_OUT) << `BIO_LINK_CLK_BIT);
	localparam logic [7:0] PORTD_OE = `BIO_PORTD_OE |
		(8'(LINK_CLK_OUT) << `BIO_LINK_CLK_BIT);

	logic [`BIO_NUM_DOUT-1:0] dout_r;
	logic [`BIO_NUM_DOUT-1:0] dout_nxt;
	logic fault_r;
	logic fault_nxt;
	logic [4:0] din_sel_r;
	bio_sermode_type mode_r;
	logic ser_err_r;
	logic de_r;
	logic src_r;
	logic [7:0] portd_r;
	logic [7:0] portc_nxt;
	logic [`BIO_NUM_PSEUDO-1:0] pseudo;

	// Pseudo inputs 11 upward; the first four come from converters 0 to 3.
	// threshold compare
	for (genvar i = 0; i < `BIO_NUM_PSEUDO; i++) begin : g_pseudo
		bio_thresh_cmp #(
			.W(ADC_BITS)
		) u_cmp (
			.aclk(aclk),
			.aresetn(aresetn),
			.code(conv_values[i*ADC_BITS +: ADC_BITS]),
			.thresh(thresh_code),
			.level(pseudo[i])
		);
	end

	// Standard inputs: IN0-5 on port E bits 2-7, IN6 on B0, IN7-10 on B2-5.
	wire [`BIO_NUM_STD_IN-1:0] din_std =
		{portb_in[5:2], portb_in[0], porte_in[7:2]};
	wire [`BIO_NUM_DIN-1:0] din_all = {pseudo, din_std};

	// Writes act only when both low byte lanes are enabled.
	wire wr_go = rb.wen && (rb.wstrb[1:0] == `BIO_FULL_LANES);
	wire [4:0] cmd_sel = rb.wdata[`BIO_SEL_MSB:`BIO_SEL_LSB];
	wire cmd_val = rb.wdata[`BIO_VAL_BIT];
	wire hit_dout = rb.waddr == `BIO_OFF_DOUT;
	wire hit_outcmd = rb.waddr == `BIO_OFF_OUTCMD;
	wire hit_relay = rb.waddr == `BIO_OFF_RELAY;
	wire hit_led = rb.waddr == `BIO_OFF_LED;
	wire hit_dinsel = rb.waddr == `BIO_OFF_DINSEL;
	wire hit_sermode = rb.waddr == `BIO_OFF_SERMODE;
	wire hit_rs485 = rb.waddr == `BIO_OFF_RS485;
	wire hit_config = rb.waddr == `BIO_OFF_CONFIG;
	wire hit_portd = rb.waddr == `BIO_OFF_PORTD;
	assign rb.wok = hit_dout || hit_outcmd || hit_relay || hit_led ||
		hit_dinsel || hit_sermode || hit_rs485 || hit_config ||
		hit_portd;

	wire outcmd_ok = cmd_sel < 5'(`BIO_NUM_DOUT);
	wire relay_ok = cmd_sel == 5'(`BIO_RELAY0);
	wire led_out_ok = cmd_sel < 5'(`BIO_NUM_OUT_LED);
	wire led_fault_ok = cmd_sel == 5'(`BIO_FAULT_LED);
	wire [7:0] ser_code = rb.wdata[`BIO_SER_CODE_MSB:0];
	wire ser_valid = ser_code <= `BIO_SER_MAX_CODE;

	// All three commands land on the same output bits, so the relay, output
	// 0 and its lamp can never disagree; the last write wins.
	always_comb begin
		dout_nxt = dout_r;
		fault_nxt = fault_r;
		if (wr_go && hit_dout) begin
			dout_nxt = rb.wdata[`BIO_NUM_DOUT-1:0];
		end
		if (wr_go && hit_outcmd && outcmd_ok) begin
			dout_nxt[cmd_sel[3:0]] = cmd_val;
		end
		if (wr_go && hit_relay && relay_ok) begin
			dout_nxt[0] = cmd_val;
		end
		if (wr_go && hit_led && led_out_ok) begin
			dout_nxt[cmd_sel[1:0]] = cmd_val;
		end
		if (wr_go && hit_led && led_fault_ok) begin
			fault_nxt = cmd_val;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dout_r <= `BIO_DOUT_RST;
			fault_r <= 1'b0;
		end else begin
			dout_r <= dout_nxt;
			fault_r <= fault_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			din_sel_r <= '0;
		end else if (wr_go && hit_dinsel) begin
			din_sel_r <= rb.wdata[4:0];
		end
	end

	// An unsupported code leaves the wiring as it was and only flags it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= BIO_SER_THREE_WIRE;
			ser_err_r <= 1'b0;
		end else if (wr_go && hit_sermode) begin
			ser_err_r <= !ser_valid;
			if (ser_valid) begin
				mode_r <= bio_sermode_type'(ser_code[0]);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			de_r <= 1'b0;
		end else if (wr_go && hit_rs485) begin
			de_r <= rb.wdata[0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_r <= SOURCING;
		end else if (wr_go && hit_config) begin
			src_r <= rb.wdata[0];
		end
	end

	// Port D carries converter selects and clock bit-banged by software.
	// link clock variant
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			portd_r <= PORTD_RST;
		end else if (wr_go && hit_portd) begin
			portd_r <= rb.wdata[7:0];
		end
	end

	wire din_bit = (din_sel_r < 5'(`BIO_NUM_DIN)) ?
		din_all[din_sel_r] : 1'b0;

	// Reads decode their own address, since a write may be held meanwhile.
	wire rh_dout = rb.raddr == `BIO_OFF_DOUT;
	wire rh_outcmd = rb.raddr == `BIO_OFF_OUTCMD;
	wire rh_relay = rb.raddr == `BIO_OFF_RELAY;
	wire rh_led = rb.raddr == `BIO_OFF_LED;
	wire rh_dinsel = rb.raddr == `BIO_OFF_DINSEL;
	wire rh_din = rb.raddr == `BIO_OFF_DIN;
	wire rh_sermode = rb.raddr == `BIO_OFF_SERMODE;
	wire rh_rs485 = rb.raddr == `BIO_OFF_RS485;
	wire rh_config = rb.raddr == `BIO_OFF_CONFIG;
	wire rh_portd = rb.raddr == `BIO_OFF_PORTD;
	assign rb.rok = rh_dout || rh_outcmd || rh_relay || rh_led ||
		rh_dinsel || rh_din || rh_sermode || rh_rs485 || rh_config ||
		rh_portd;
	always_comb begin
		rb.rdata = '0;
		unique case (1'b1)
			rh_dout, rh_outcmd: rb.rdata[`BIO_NUM_DOUT-1:0] = dout_r;
			rh_relay: rb.rdata[0] = dout_r[0];
			rh_led: rb.rdata[4:0] = {fault_r, dout_r[3:0]};
			rh_dinsel: rb.rdata[4:0] = din_sel_r;
			rh_din: rb.rdata[0] = din_bit;
			rh_sermode: begin
				rb.rdata[0] = mode_r;
				rb.rdata[`BIO_SER_ERR_BIT] = ser_err_r;
			end
			rh_rs485: rb.rdata[0] = de_r;
			rh_config: rb.rdata[0] = src_r;
			rh_portd: rb.rdata[15:0] = {portd_in, portd_r};
			default: rb.rdata = '0;
		endcase
	end

	// Serial pin routing: C0 RS-485 TX, C2 port C TX or port B RTS,
	// C4 port B TX, C6 programming TX; odd bits are the receive side.
	// serial wiring mode
	always_comb begin
		portc_nxt = 8'hFF;
		portc_nxt[0] = uart_d_txd;
		portc_nxt[2] = (mode_r == BIO_SER_FIVE_WIRE) ?
			uart_b_rts : uart_c_txd;
		portc_nxt[4] = uart_b_txd;
		portc_nxt[6] = uart_a_txd;
	end

	// Pins are registered so that nothing glitches at the board edge.
	// transmit lines idle high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			portc_out <= 8'hFF;
			uart_a_rxd <= 1'b1;
			uart_b_rxd <= 1'b1;
			uart_b_cts <= 1'b0;
			uart_c_rxd <= 1'b1;
			uart_d_rxd <= 1'b1;
		end else begin
			portc_out <= portc_nxt;
			uart_d_rxd <= portc_in[1];
			uart_b_rxd <= portc_in[5];
			uart_a_rxd <= portc_in[7];
			// C3 is CTS in mode 1
			if (mode_r == BIO_SER_FIVE_WIRE) begin
				uart_b_cts <= portc_in[3];
				uart_c_rxd <= 1'b1;
			end else begin
				uart_b_cts <= 1'b0;
				uart_c_rxd <= portc_in[3];
			end
		end
	end

	// Output bits are driver gates: 1 switches the high-current driver on.
	// port directions
	assign porta_out = dout_r[7:0];
	assign porta_oe = `BIO_PORTA_OE;
	assign porte_out = dout_r[9:8];
	assign portb_oe = `BIO_PORTB_OE;
	assign portb_out = {fault_r, de_r, 6'h00};
	assign portd_out = portd_r;
	assign portd_oe = PORTD_OE;
	assign drive_sourcing = src_r;
	assign relay_energize = dout_r[0];
	assign lamps = {fault_r, dout_r[3:0]};
	assign driver_enable_line = de_r;
	assign fault_indicator_bit = fault_r;
	assign serial_mode = mode_r;
endmodule : bio_port_ctrl

/* verif/bio_port_ctrl_monitor.sv */
// Concurrent checks on the board I/O block pins.
`timescale 1ns/1ps
module bio_port_chk #(
	parameter bit LINK_CLK_OUT = 1'h0,
	parameter bit SOURCING = 1'h0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] porta_out,
	input wire logic [7:0] porta_oe,
	input wire logic [7:0] portb_out,
	input wire logic [7:0] portb_oe,
	input wire logic [7:0] portc_out,
	input wire logic [7:0] portd_oe,
	input wire logic [1:0] porte_out,
	input wire logic drive_sourcing,
	input wire logic relay_energize,
	input wire logic [4:0] lamps,
	input wire logic driver_enable_line,
	input wire logic fault_indicator_bit,
	input wire bio_pkg::bio_sermode_type serial_mode,
	input wire logic uart_b_rts,
	input wire logic uart_c_txd,
	input wire logic uart_d_txd,
	input wire logic uart_b_cts
);
	import bio_pkg::*;
	logic c2_src;
	// Port C bit 2 carries handshake in five-wire mode, data otherwise.
	assign c2_src = serial_mode ? uart_b_rts : uart_c_txd;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	oe_map_a: assert property (porta_oe == 8'hFF && portb_oe == 8'hC0)
		else $error("port direction map wrong");
	link_dir_a: assert property (
		portd_oe == (8'hF3 | {4'h0, LINK_CLK_OUT, 3'h0}))
		else $error("port D direction wrong");
	reset_idle_a: assert property ($rose(aresetn) |->
		porta_out == 8'h00 && porte_out == 2'h0 && lamps == 5'h00 &&
		portb_out == 8'h00 && portc_out == 8'hFF)
		else $error("outputs not idle after reset");
	src_reset_a: assert property (
		$rose(aresetn) |-> drive_sourcing == SOURCING)
		else $error("drive polarity reset wrong");
	shared_line_a: assert property (
		relay_energize == porta_out[0] && lamps[3:0] == porta_out[3:0])
		else $error("shared output line split");
	fault_lamp_a: assert property (
		lamps[4] == fault_indicator_bit && portb_out[7] == lamps[4])
		else $error("fault lamp pin mismatch");
	de_pin_a: assert property (portb_out[6] == driver_enable_line)
		else $error("driver enable pin mismatch");
	idle_high_a: assert property ((portc_out & 8'hAA) == 8'hAA)
		else $error("idle port C lines not high");
	tx_lag_a: assert property (
		$past(aresetn) |-> portc_out[0] == $past(uart_d_txd))
		else $error("transmit line not following");
	mode_route_a: assert property (
		$past(aresetn) |-> portc_out[2] == $past(c2_src))
		else $error("port C bit 2 routing wrong");
	cts_off_a: assert property ($past(aresetn) &&
		$past(serial_mode) == BIO_SER_THREE_WIRE &&
		serial_mode == BIO_SER_THREE_WIRE |-> !uart_b_cts)
		else $error("handshake active in three-wire mode");
endmodule : bio_port_chk
bind bio_port_ctrl bio_port_chk #(
	.LINK_CLK_OUT(LINK_CLK_OUT),
	.SOURCING(SOURCING)
) i_bio_port_chk (
	.aclk, .aresetn, .porta_out, .porta_oe, .portb_out, .portb_oe,
	.portc_out, .portd_oe, .porte_out, .drive_sourcing, .relay_energize,
	.lamps, .driver_enable_line, .fault_indicator_bit, .serial_mode,
	.uart_b_rts, .uart_c_txd, .uart_d_txd, .uart_b_cts
);

/* verif/bio_far_model.sv */
// Far-side pin model: input sources and receive lines.
`timescale 1ns/1ps
module bio_far_model (
	input wire logic [10:0] std_in,
	input wire logic [3:0] rx_in,
	output logic [7:0] portb_in,
	output logic [7:0] portc_in,
	output logic [7:0] portd_in,
	output logic [7:0] porte_in
);
	// Unused clock input and even port C lines sit at their pull-up level.
	assign porte_in = {std_in[5:0], 2'h3};
	assign portb_in = {2'h3, std_in[10:7], 1'h1, std_in[6]};
	assign portc_in = {rx_in[3], 1'h1, rx_in[2], 1'h1, rx_in[1], 1'h1,
		rx_in[0], 1'h1};
	assign portd_in = 8'hA5;
endmodule : bio_far_model

/* verif/tb.sv */
// Self-checking bench of the board I/O port block.
`timescale 1ns/1ps
`include "bio_defs.svh"
module tb;
	import bio_pkg::*;
	localparam int THR = `BIO_THRESH_MV * 4096 / `BIO_FULL_SCALE_MV;
	logic aclk, aresetn;
	logic [31:0] s_axi_awaddr, s_axi_araddr;
	bio_word_type s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, rx_in;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, drive_sourcing, relay_energize;
	logic [1:0] s_axi_bresp, s_axi_rresp, porte_out;
	logic [7:0] porta_out, porta_oe, portb_in, portb_out, portb_oe;
	logic [7:0] portc_in, portc_out, portd_in, portd_out, portd_oe, porte_in;
	logic [`BIO_NUM_PSEUDO*`BIO_ADC_BITS-1:0] conv_values;
	logic driver_enable_line, fault_indicator_bit, uart_a_txd, uart_b_txd;
	logic uart_b_rts, uart_c_txd, uart_d_txd;
	logic uart_a_rxd, uart_b_rxd, uart_b_cts, uart_c_rxd, uart_d_rxd;
	logic [4:0] lamps;
	logic [10:0] std_in;
	bio_sermode_type serial_mode;
	int errors, n_compared;
	bio_port_ctrl #(.LINK_CLK_OUT(1'h1)) i_bio_port_ctrl (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .porta_out, .porta_oe, .portb_in,
		.portb_out, .portb_oe, .portc_in, .portc_out, .portd_in, .portd_out,
		.portd_oe, .porte_in, .porte_out, .conv_values, .drive_sourcing,
		.relay_energize, .lamps, .driver_enable_line, .fault_indicator_bit,
		.serial_mode, .uart_a_txd, .uart_b_txd, .uart_b_rts, .uart_c_txd,
		.uart_d_txd, .uart_a_rxd, .uart_b_rxd, .uart_b_cts, .uart_c_rxd,
		.uart_d_rxd
	);
	bio_far_model i_bio_far_model (.std_in, .rx_in, .portb_in, .portc_in,
		.portd_in, .porte_in);
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit ga, gw;
		ga = 0;
		gw = 0;
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (!ga && s_axi_awready) begin
				ga = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (!gw && s_axi_wready) begin
				gw = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : axi_wr
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk("bresp", `BIO_RESP_OKAY, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		chk("rresp", `BIO_RESP_OKAY, s_axi_rresp);
	endtask : rd
	task automatic t_reset();
		chk("porta", 8'h00, porta_out);
		chk("portb", 8'h00, portb_out);
		chk("porte", 2'h0, porte_out);
		chk("portc", 8'hFF, portc_out);
		chk("portd", 8'hFB, portd_out);
		chk("portd_oe", 8'hFB, portd_oe);
		chk("sourcing", 1'h0, drive_sourcing);
		$display("test reset done");
	endtask : t_reset
	task automatic t_dout();
		logic [9:0] e;
		logic [31:0] v;
		e = 10'h000;
		for (int c = 0; c <= 10; c++) begin
			wr(`BIO_OFF_OUTCMD, {19'h0, 5'(c), 8'h01});
			if (c < 10)
				e[c] = 1'h1;
			chk("dout", e, {porte_out, porta_out});
		end
		wr(`BIO_OFF_OUTCMD, 32'h00000500);
		e[5] = 1'h0;
		rd(`BIO_OFF_DOUT, v);
		chk("dout_reg", e, v);
		wr(`BIO_OFF_CONFIG, 32'h00000001);
		chk("sourcing", 1'h1, drive_sourcing);
		wr(`BIO_OFF_DOUT, 32'h00000000);
		$display("test outputs done");
	endtask : t_dout
	task automatic t_relay();
		logic [4:0] e;
		// Output zero follows the relay, since both share one line.
		wr(`BIO_OFF_RELAY, 32'h00000001);
		chk("relay", 1'h1, relay_energize);
		chk("digital_output_zero", 1'h1, porta_out[0]);
		wr(`BIO_OFF_RELAY, 32'h00000100);
		chk("relay", 1'h1, relay_energize);
		wr(`BIO_OFF_RELAY, 32'h00000000);
		chk("relay", 1'h0, relay_energize);
		e = 5'h00;
		for (int c = 0; c <= 4; c++) begin
			wr(`BIO_OFF_LED, {19'h0, 5'(c), 8'h01});
			e[c] = 1'h1;
			chk("lamps", e, lamps);
		end
		chk("relay", 1'h1, relay_energize);
		chk("fault", 1'h1, fault_indicator_bit);
		wr(`BIO_OFF_LED, 32'h00000400);
		chk("fault", 1'h0, fault_indicator_bit);
		$display("test relay done");
	endtask : t_relay
	task automatic t_din();
		logic [31:0] v;
		logic e;
		for (int c = 0; c <= 22; c++) begin
			wr(`BIO_OFF_DINSEL, 32'(c));
			rd(`BIO_OFF_DIN, v);
			if (c < 11)
				e = std_in[c];
			else if (c < 22)
				e = conv_values[(c - 11) * 12 +: 12] >= THR;
			else
				e = 1'h0;
			chk("din", {31'h0, e}, v);
		end
		$display("test inputs done");
	endtask : t_din
	task automatic t_ser();
		logic [31:0] v;
		logic [1:0] r;
		wr(`BIO_OFF_SERMODE, 32'h00000001);
		uart_b_rts <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("c2_rts", 1'h0, portc_out[2]);
		chk("rx_five", 5'h16, {uart_a_rxd, uart_b_rxd, uart_b_cts, uart_c_rxd, uart_d_rxd});
		axi_wr(`BIO_OFF_SERMODE, 32'h00000002, r);
		rd(`BIO_OFF_SERMODE, v);
		chk("sermode_bad", 32'h00000101, v);
		wr(`BIO_OFF_SERMODE, 32'h00000000);
		rd(`BIO_OFF_SERMODE, v);
		chk("sermode_ok", 32'h00000000, v);
		chk("c2_txd", 1'h1, portc_out[2]);
		rx_in <= 4'h5;
		repeat (2) @(posedge aclk);
		chk("rx_three", 5'h09, {uart_a_rxd, uart_b_rxd, uart_b_cts, uart_c_rxd, uart_d_rxd});
		$display("test serial done");
	endtask : t_ser
	task automatic t_485();
		logic [1:0] r;
		logic [31:0] v;
		wr(`BIO_OFF_RS485, 32'h00000001);
		chk("de", 1'h1, portb_out[6]);
		wr(`BIO_OFF_RS485, 32'h00000000);
		chk("de", 1'h0, driver_enable_line);
		s_axi_wstrb <= 4'hC;
		wr(`BIO_OFF_DOUT, 32'h00000000);
		s_axi_wstrb <= 4'hF;
		chk("porta_strb", 8'h0F, porta_out);
		wr(`BIO_OFF_PORTD, 32'h00000012);
		chk("portd", 8'h12, portd_out);
		rd(`BIO_OFF_PORTD, v);
		chk("portd_reg", 32'h0000A512, v);
		axi_wr(8'h40, 32'hFFFFFFFF, r);
		chk("unmapped", `BIO_RESP_SLVERR, r);
		chk("porta", 8'h0F, porta_out);
		axi_wr(`BIO_OFF_DIN, 32'h00000001, r);
		chk("din_write", `BIO_RESP_SLVERR, r);
		$display("test line driver done");
	endtask : t_485
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		final_report();
	end
	initial begin
		errors = 0;
		n_compared = 0;
		aresetn = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		s_axi_awaddr = 32'h0;
		s_axi_araddr = 32'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{uart_a_txd, uart_b_txd, uart_b_rts, uart_c_txd, uart_d_txd} = 5'h1F;
		std_in = 11'h5A3;
		rx_in = 4'hA;
		for (int i = 0; i < 11; i++)
			conv_values[i * 12 +: 12] = 12'(THR - 2 + i);
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_dout();
		t_relay();
		t_din();
		t_ser();
		t_485();
		final_report();
	end
endmodule : tb
